// *** design/adirq_dev.sv ***
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "adirq_map.svh"

module adirq_dev
    import adirq_pkg::*;
#(
    parameter int NUM_SRC = `ADIRQ_NUM_SRC
) (
    // Clock and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESET_I,
    // Die link
    adirq_if.dev_mp         LINK,
    // Power block conditions
    input  wire logic       SUPPLY_LOW_COND_I,
    input  wire logic       DIE_HOT_COND_I,
    input  wire logic       CRANKING_EN_I,
    input  wire logic       LOW_POWER_I,
    input  wire logic       CRANK_WAKE_I,
    // Line driver
    input  wire logic       LINE_DRV_HOT_COND_I,
    // Timer
    input  wire logic [3:0] TIMER_CHAN_I,
    input  wire logic       TIMER_WRAP_I,
    // Serial interface
    input  wire logic       SERIAL_ERR_I,
    input  wire logic       SERIAL_TX_I,
    input  wire logic       SERIAL_RX_I,
    // Acquisition
    input  wire logic       CURRENT_DONE_FLAG_I,
    input  wire logic       VOLTAGE_DONE_FLAG_I,
    input  wire logic       RECAL_REQ_I,
    // Lifetime counter
    input  wire logic       LIFETIME_OVF_I,
    input  wire logic       LIFETIME_IRQ_EN_I,
    // Power block control
    output var  logic       HP_LV_THRESH_EN_O
);

    // Lowest index wins; code is index plus one, zero when idle
    function automatic logic [3:0] prio_code(input adirq_src_t v);
        logic [3:0] code;
        code = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                code = 4'(i + 1);
            end
        end
        return code;
    endfunction

    // Address match on a link request
    function automatic logic hit(input adirq_byte_t a, input adirq_byte_t ofs);
        return a == ofs;
    endfunction

    // Registers
    logic [2:0]  cond_prev_ff;
    logic [2:0]  sticky_ff;
    adirq_byte_t gate_hi_ff;
    adirq_byte_t gate_lo_ff;
    adirq_src_t  pend_ff;
    logic [3:0]  code_ff;
    logic        irq_ff;
    logic        ack_ff;
    adirq_byte_t rdata_ff;
    logic        hp_thresh_ff;

    // Next values
    logic [2:0]  nxt_cond_prev;
    logic [2:0]  nxt_sticky;
    adirq_src_t  nxt_pend;
    logic [3:0]  nxt_code;
    logic        nxt_irq;
    adirq_byte_t nxt_rdata;

    // Link decode
    wire         link_wr     = LINK.link_req & LINK.link_we;
    wire         link_rd     = LINK.link_req & ~LINK.link_we;
    wire         wr_pwr      = link_wr & hit(LINK.link_addr, `ADIRQ_OFS_PWR_STATUS);
    wire         wr_gate_hi  = link_wr & hit(LINK.link_addr, `ADIRQ_OFS_GATE_HI);
    wire         wr_gate_lo  = link_wr & hit(LINK.link_addr, `ADIRQ_OFS_GATE_LO);
    wire         rd_line     = link_rd & hit(LINK.link_addr, `ADIRQ_OFS_LINE_DRV);

    // Conditions of the three latched sources
    wire  [2:0]  cond        = {LINE_DRV_HOT_COND_I, DIE_HOT_COND_I, SUPPLY_LOW_COND_I};
    wire  [2:0]  cond_rise   = cond & ~cond_prev_ff;

    // Set terms; supply low suppressed in cranking mode
    wire  [2:0]  sticky_set;
    assign sticky_set[0] = (cond_rise[0] & ~CRANKING_EN_I) | CRANK_WAKE_I;
    assign sticky_set[1] = cond_rise[1];
    assign sticky_set[2] = cond_rise[2];

    // Clear terms from the controller acknowledge
    wire  [2:0]  sticky_clr;
    assign sticky_clr[0] = wr_pwr & LINK.link_wdata[`ADIRQ_BIT_SUPPLY_LOW];
    assign sticky_clr[1] = wr_pwr & LINK.link_wdata[`ADIRQ_BIT_DIE_HOT];
    assign sticky_clr[2] = rd_line;

    // Latched sources: set wins, clear refused while condition holds
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sticky
            assign nxt_sticky[g] = sticky_set[g] |
                                   (sticky_ff[g] & ~(sticky_clr[g] & ~cond[g]));
        end
    endgenerate
    assign nxt_cond_prev = cond;

    // Source vector in mirror order
    wire         meas_done   = CURRENT_DONE_FLAG_I | VOLTAGE_DONE_FLAG_I;
    wire         life_ovf    = LIFETIME_OVF_I & LIFETIME_IRQ_EN_I;
    assign nxt_pend = {2'b00, RECAL_REQ_I, life_ovf, meas_done,
                       SERIAL_RX_I, SERIAL_TX_I, SERIAL_ERR_I,
                       TIMER_WRAP_I, TIMER_CHAN_I, sticky_ff};

    // Global gating of the sources
    wire  adirq_src_t gate_vec = {gate_lo_ff, gate_hi_ff};
    wire  adirq_src_t gated    = nxt_pend & gate_vec;
    assign nxt_irq  = |gated;
    assign nxt_code = prio_code(gated);

    // Power status shows live conditions only
    wire  adirq_byte_t pwr_rd  = {6'h00, DIE_HOT_COND_I, SUPPLY_LOW_COND_I};
    wire  adirq_byte_t line_rd = {7'h00, LINE_DRV_HOT_COND_I};

    // Read selection; mirror and code reads have no side effect
    assign nxt_rdata =
        hit(LINK.link_addr, `ADIRQ_OFS_PEND_HI)    ? pend_ff[7:0] :
        hit(LINK.link_addr, `ADIRQ_OFS_PEND_LO)    ? pend_ff[15:8] :
        hit(LINK.link_addr, `ADIRQ_OFS_PRIO_CODE)  ? {4'h0, code_ff} :
        hit(LINK.link_addr, `ADIRQ_OFS_GATE_HI)    ? gate_hi_ff :
        hit(LINK.link_addr, `ADIRQ_OFS_GATE_LO)    ? gate_lo_ff :
        hit(LINK.link_addr, `ADIRQ_OFS_PWR_STATUS) ? pwr_rd :
        hit(LINK.link_addr, `ADIRQ_OFS_LINE_DRV)   ? line_rd : 8'h00;

    // Latched sources and edge history
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            cond_prev_ff <= 3'b000;
            sticky_ff    <= 3'b000;
        end else begin
            cond_prev_ff <= nxt_cond_prev;
            sticky_ff    <= nxt_sticky;
        end
    end

    // Global gate registers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            gate_hi_ff <= `ADIRQ_RST_GATE_HI;
            gate_lo_ff <= `ADIRQ_RST_GATE_LO;
        end else begin
            if (wr_gate_hi) begin
                gate_hi_ff <= LINK.link_wdata;
            end
            if (wr_gate_lo) begin
                gate_lo_ff <= LINK.link_wdata & `ADIRQ_LO_MASK;
            end
        end
    end

    // Mirror, priority code and interrupt line
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            pend_ff <= 16'h0000;
            code_ff <= 4'h0;
            irq_ff  <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            code_ff <= nxt_code;
            irq_ff  <= nxt_irq;
        end
    end

    // Link answer one cycle after each request
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= LINK.link_req;
            if (link_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // Precise low-voltage threshold in cranking low-power mode
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            hp_thresh_ff <= 1'b0;
        end else begin
            hp_thresh_ff <= CRANKING_EN_I & LOW_POWER_I;
        end
    end

    // Outputs straight from flip-flops
    assign LINK.link_ack     = ack_ff;
    assign LINK.link_rdata   = rdata_ff;
    assign LINK.die_irq_line = irq_ff;
    assign HP_LV_THRESH_EN_O = hp_thresh_ff;

endmodule

`default_nettype wire

// *** inc/adirq_map.svh ***
// Functional notes
// - Enabled pending event drives interrupt line
// - Pending mirror shows every source
// - Mirror read clears nothing
// - Priority code reports highest-priority enabled pending source
// - Priority code read clears nothing
// - Controller acknowledges in originating block
// - Two global gate bytes enable sources
// - Fourteen sources implemented
// - Write one clears supply-low pending
// - Write one clears die-hot; flag live
// - Clear refused while condition present
// - New interrupt needs condition reappearing
// - Supply-low flag shows live condition
// - Cranking disables supply-low; with low power, enables precise threshold
// - Cranking wake-up sets supply-low bit
// - Line register read clears overheat pending
// - Measurement done from current or voltage
// - Lifetime overflow with enable raises source
// - Recalibration request raises source
// - Mirror bit one when pending
`ifndef ADIRQ_MAP_SVH
`define ADIRQ_MAP_SVH

// Die link register offsets
`define ADIRQ_OFS_PWR_STATUS   8'h02
`define ADIRQ_OFS_PEND_HI      8'h08
`define ADIRQ_OFS_PEND_LO      8'h09
`define ADIRQ_OFS_PRIO_CODE    8'h0A
`define ADIRQ_OFS_RESERVED     8'h0B
`define ADIRQ_OFS_GATE_HI      8'h0C
`define ADIRQ_OFS_GATE_LO      8'h0D
`define ADIRQ_OFS_LINE_DRV     8'h10

// Field positions
`define ADIRQ_BIT_SUPPLY_LOW   0
`define ADIRQ_BIT_DIE_HOT      1
`define ADIRQ_BIT_LINE_HOT     0
`define ADIRQ_NUM_SRC          14
`define ADIRQ_LO_MASK          8'h3F

// Reset values of the global gates
`define ADIRQ_RST_GATE_HI      8'hFF
`define ADIRQ_RST_GATE_LO      8'h3F

// Controller register byte offsets and bit positions on the Avalon side
`define ADIRQ_AV_ADDR          4'h0
`define ADIRQ_AV_WDATA         4'h4
`define ADIRQ_AV_CMD           4'h8
`define ADIRQ_AV_STATUS        4'hC
`define ADIRQ_CMD_GO           0
`define ADIRQ_CMD_WRITE        1
`define ADIRQ_ST_BUSY          0
`define ADIRQ_ST_IRQ           1

`endif

// *** inc/adirq_pkg.sv ***
package adirq_pkg;

    typedef logic [7:0]  adirq_byte_t;
    typedef logic [15:0] adirq_src_t;

    // Controller sequencer, Gray coded
    typedef enum logic [1:0] {
        ADIRQ_IDLE = 2'b00,
        ADIRQ_WAIT = 2'b01
    } adirq_host_state_t;

endpackage

// *** inc/adirq_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface adirq_if;
    import adirq_pkg::*;

    // Register access from the controller
    logic        link_req;
    logic        link_we;
    adirq_byte_t link_addr;
    adirq_byte_t link_wdata;
    // Answer from the analog die
    logic        link_ack;
    adirq_byte_t link_rdata;
    // Interrupt toward the controller
    logic        die_irq_line;

    modport dev_mp (
        input  link_req,
        input  link_we,
        input  link_addr,
        input  link_wdata,
        output link_ack,
        output link_rdata,
        output die_irq_line
    );

    modport host_mp (
        output link_req,
        output link_we,
        output link_addr,
        output link_wdata,
        input  link_ack,
        input  link_rdata,
        input  die_irq_line
    );
endinterface

`default_nettype wire

// *** design/adirq_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adirq_map.svh"

module adirq_host
    import adirq_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_I,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output var  logic [31:0] AVS_READDATA_O,
    output var  logic        AVS_WAITREQUEST_O,
    // Die link
    adirq_if.host_mp         LINK
);

    // Registers
    adirq_host_state_t state_ff;
    adirq_byte_t       addr_ff;
    adirq_byte_t       wdata_ff;
    adirq_byte_t       last_rd_ff;
    logic              irq_ff;
    logic              wait_ff;
    logic [31:0]       readdata_ff;
    logic              req_ff;
    logic              we_ff;
    adirq_byte_t       link_addr_ff;
    adirq_byte_t       link_wdata_ff;

    // Bus decode: write takes effect on the edge waitrequest is seen low
    wire        wr_take  = AVS_WRITE_I & ~wait_ff & AVS_BYTEENABLE_I[0];
    wire        wr_addr  = wr_take & (AVS_ADDRESS_I == `ADIRQ_AV_ADDR);
    wire        wr_wdata = wr_take & (AVS_ADDRESS_I == `ADIRQ_AV_WDATA);
    wire        wr_cmd   = wr_take & (AVS_ADDRESS_I == `ADIRQ_AV_CMD);
    wire        busy     = (state_ff != ADIRQ_IDLE);
    wire        start    = wr_cmd & AVS_WRITEDATA_I[`ADIRQ_CMD_GO] & ~busy;

    // Read selection; unmapped reads return zero
    wire [31:0] status   = {16'h0000, last_rd_ff, 6'h00, irq_ff, busy};
    wire [31:0] rd_mux   =
        (AVS_ADDRESS_I == `ADIRQ_AV_ADDR)   ? {24'h00_0000, addr_ff} :
        (AVS_ADDRESS_I == `ADIRQ_AV_WDATA)  ? {24'h00_0000, wdata_ff} :
        (AVS_ADDRESS_I == `ADIRQ_AV_STATUS) ? status : 32'h0000_0000;

    // Avalon answer one cycle after the request appears
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            wait_ff     <= 1'b1;
            readdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~((AVS_READ_I | AVS_WRITE_I) & wait_ff);
            if (AVS_READ_I & wait_ff) begin
                readdata_ff <= rd_mux;
            end
        end
    end

    // Controller registers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            addr_ff  <= 8'h00;
            wdata_ff <= 8'h00;
            irq_ff   <= 1'b0;
        end else begin
            if (wr_addr) begin
                addr_ff <= AVS_WRITEDATA_I[7:0];
            end
            if (wr_wdata) begin
                wdata_ff <= AVS_WRITEDATA_I[7:0];
            end
            irq_ff <= LINK.die_irq_line;
        end
    end

    // Link sequencer: one request pulse, then wait for the answer
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            state_ff      <= ADIRQ_IDLE;
            req_ff        <= 1'b0;
            we_ff         <= 1'b0;
            link_addr_ff  <= 8'h00;
            link_wdata_ff <= 8'h00;
            last_rd_ff    <= 8'h00;
        end else begin
            req_ff <= 1'b0;
            case (state_ff)
                ADIRQ_IDLE: begin
                    if (start) begin
                        req_ff        <= 1'b1;
                        we_ff         <= AVS_WRITEDATA_I[`ADIRQ_CMD_WRITE];
                        link_addr_ff  <= addr_ff;
                        link_wdata_ff <= wdata_ff;
                        state_ff      <= ADIRQ_WAIT;
                    end
                end
                ADIRQ_WAIT: begin
                    if (LINK.link_ack) begin
                        if (!we_ff) begin
                            last_rd_ff <= LINK.link_rdata;
                        end
                        state_ff <= ADIRQ_IDLE;
                    end
                end
                default: begin
                    state_ff <= ADIRQ_IDLE;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign AVS_READDATA_O    = readdata_ff;
    assign AVS_WAITREQUEST_O = wait_ff;
    assign LINK.link_req     = req_ff;
    assign LINK.link_we      = we_ff;
    assign LINK.link_addr    = link_addr_ff;
    assign LINK.link_wdata   = link_wdata_ff;

endmodule

`default_nettype wire

// *** tb/adirq_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module adirq_monitor
    import adirq_pkg::*;
(
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_I,
    // Die link
    input wire logic        link_req,
    input wire logic        link_we,
    input wire adirq_byte_t link_addr,
    input wire adirq_byte_t link_wdata,
    input wire logic        link_ack,
    input wire adirq_byte_t link_rdata,
    input wire logic        die_irq_line
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    // Read requests of interest
    wire rd_code = link_req && !link_we && link_addr == 8'h0A;
    wire rd_pl   = link_req && !link_we && link_addr == 8'h09;
    wire rd_gl   = link_req && !link_we && link_addr == 8'h0D;

    a_ack_after_req: assert property (link_req |=> link_ack)
        else $error("link request not answered next cycle");
    a_ack_has_req: assert property (link_ack |-> $past(link_req))
        else $error("link answer without request");
    a_ack_one_cycle: assert property (link_ack |=> !link_ack)
        else $error("link answer longer than one cycle");
    a_mirror_lo_top: assert property (rd_pl |=> link_rdata[7:6] == 2'b00)
        else $error("unused mirror bits not zero");
    a_gate_lo_top: assert property (rd_gl |=> link_rdata[7:6] == 2'b00)
        else $error("unused gate bits not zero");
    a_code_range: assert property (rd_code |=> link_rdata <= 8'h0E)
        else $error("priority code out of range");
    a_code_idle: assert property (rd_code && !die_irq_line ##1 !die_irq_line
        |-> link_rdata == 8'h00)
        else $error("priority code nonzero while line idle");
    a_code_busy: assert property (rd_code && die_irq_line ##1 die_irq_line
        |-> link_rdata != 8'h00)
        else $error("priority code zero while line raised");

    // Main scenarios
    c_code_seen: cover property (rd_code ##1 link_rdata != 8'h00);
    c_write_seen: cover property (link_req && link_we);
    c_irq_rise: cover property ($rose(die_irq_line));
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adirq_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench
    import adirq_pkg::*;
;
    localparam adirq_byte_t ph = `ADIRQ_OFS_PEND_HI;
    localparam adirq_byte_t pl = `ADIRQ_OFS_PEND_LO;
    localparam adirq_byte_t pc = `ADIRQ_OFS_PRIO_CODE;
    localparam adirq_byte_t gh = `ADIRQ_OFS_GATE_HI;
    localparam adirq_byte_t gl = `ADIRQ_OFS_GATE_LO;
    localparam adirq_byte_t ps = `ADIRQ_OFS_PWR_STATUS;
    localparam adirq_byte_t lr = `ADIRQ_OFS_LINE_DRV;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  av_a = 4'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rdata;
    logic [31:0] av_q;
    logic        av_wait;
    logic        sup = 1'b0, hot = 1'b0, lin = 1'b0, crank = 1'b0;
    logic        lowp = 1'b0, wake = 1'b0, volt = 1'b0, lt_en = 1'b0;
    logic [15:0] src = 16'h0;
    logic        thr;
    adirq_byte_t lq;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;

    adirq_if adirq_if_i ();
    wire irq = adirq_if_i.die_irq_line;

    adirq_dev adirq_dev_i (.CORE_CLK_I(clk), .RESET_I(rst), .LINK(adirq_if_i.dev_mp),
        .SUPPLY_LOW_COND_I(sup), .DIE_HOT_COND_I(hot), .CRANKING_EN_I(crank),
        .LOW_POWER_I(lowp), .CRANK_WAKE_I(wake), .LINE_DRV_HOT_COND_I(lin),
        .TIMER_CHAN_I(src[6:3]), .TIMER_WRAP_I(src[7]), .SERIAL_ERR_I(src[8]),
        .SERIAL_TX_I(src[9]), .SERIAL_RX_I(src[10]), .CURRENT_DONE_FLAG_I(src[11]),
        .VOLTAGE_DONE_FLAG_I(volt), .RECAL_REQ_I(src[13]), .LIFETIME_OVF_I(src[12]),
        .LIFETIME_IRQ_EN_I(lt_en), .HP_LV_THRESH_EN_O(thr));
    adirq_host adirq_host_i (.CORE_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(av_a),
        .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
        .LINK(adirq_if_i.host_mp));
    adirq_monitor adirq_monitor_i (.CORE_CLK_I(clk), .RESET_I(rst),
        .link_req(adirq_if_i.link_req), .link_we(adirq_if_i.link_we),
        .link_addr(adirq_if_i.link_addr), .link_wdata(adirq_if_i.link_wdata),
        .link_ack(adirq_if_i.link_ack), .link_rdata(adirq_if_i.link_rdata),
        .die_irq_line(irq));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // One Avalon access, held until waitrequest is seen low
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        av_a <= a;
        av_wr <= w;
        av_rd <= !w;
        av_wd <= d;
        do begin
            @(posedge clk);
        end while (av_wait !== 1'b0);
        av_q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clk);
    endtask

    // One die link access through the controller registers
    task automatic lk(input adirq_byte_t off, input logic w, input adirq_byte_t d);
        av(`ADIRQ_AV_ADDR, 1'b1, {24'h0, off});
        if (w) av(`ADIRQ_AV_WDATA, 1'b1, {24'h0, d});
        av(`ADIRQ_AV_CMD, 1'b1, {30'h0, w, 1'b1});
        do begin
            av(`ADIRQ_AV_STATUS, 1'b0, 32'h0);
        end while (av_q[0] !== 1'b0);
        lq = av_q[15:8];
    endtask

    // Read a die register and compare
    task automatic ex(input adirq_byte_t off, input adirq_byte_t e);
        lk(off, 1'b0, 8'h00);
        `CHK(lq, e)
    endtask

    task automatic t_reset;
        ex(gh, `ADIRQ_RST_GATE_HI);
        ex(gl, `ADIRQ_RST_GATE_LO);
        ex(pc, 8'h00);
        ex(`ADIRQ_OFS_RESERVED, 8'h00);
        `CHK(irq, 1'b0)
        `CHK(av_q[1], 1'b0)
    endtask

    // Each live source alone: mirror bit, code, line, reads clear nothing
    task automatic t_sources;
        logic [15:0] e;
        lt_en <= 1'b1;
        for (int i = 3; i < 14; i++) begin
            e = 16'h1 << i;
            src <= e;
            repeat (3) @(posedge clk);
            ex(ph, e[7:0]);
            ex(pl, e[15:8]);
            ex(pc, 8'(i + 1));
            ex(ph, e[7:0]);
            ex(pc, 8'(i + 1));
            `CHK(irq, 1'b1)
            `CHK(av_q[1], 1'b1)
            src <= 16'h0;
            repeat (3) @(posedge clk);
            `CHK(irq, 1'b0)
        end
        volt <= 1'b1;
        repeat (3) @(posedge clk);
        ex(pl, 8'h08);
        volt <= 1'b0;
        lt_en <= 1'b0;
        src <= 16'h1000;
        repeat (3) @(posedge clk);
        ex(pl, 8'h00);
        src <= 16'h0;
    endtask

    // Two sources, then gates closed one by one
    task automatic t_prio;
        src <= 16'h2020;
        repeat (3) @(posedge clk);
        ex(pc, 8'h06);
        lk(gh, 1'b1, 8'hDF);
        ex(pc, 8'h0E);
        ex(ph, 8'h20);
        lk(gl, 1'b1, 8'h00);
        ex(gl, 8'h00);
        ex(pc, 8'h00);
        `CHK(irq, 1'b0)
        `CHK(av_q[1], 1'b0)
        lk(gh, 1'b1, 8'hFF);
        lk(gl, 1'b1, 8'h3F);
        src <= 16'h0;
        repeat (3) @(posedge clk);
    endtask

    // Latched sources: refused clears, live flags, acknowledge, reappearance
    task automatic t_latch;
        sup <= 1'b1;
        hot <= 1'b1;
        lin <= 1'b1;
        repeat (4) @(posedge clk);
        ex(ph, 8'h07);
        ex(ps, 8'h03);
        lk(ps, 1'b1, 8'h03);
        lk(lr, 1'b0, 8'h00);
        ex(ph, 8'h07);
        sup <= 1'b0;
        hot <= 1'b0;
        lin <= 1'b0;
        repeat (3) @(posedge clk);
        ex(ps, 8'h00);
        ex(ph, 8'h07);
        lk(ps, 1'b1, 8'h01);
        ex(ph, 8'h06);
        lk(ps, 1'b1, 8'h02);
        ex(ph, 8'h04);
        lk(lr, 1'b0, 8'h00);
        ex(ph, 8'h00);
        sup <= 1'b1;
        repeat (4) @(posedge clk);
        ex(ph, 8'h01);
        sup <= 1'b0;
        repeat (3) @(posedge clk);
        lk(ps, 1'b1, 8'h01);
    endtask

    // Cranking mode: supply-low edge ignored, wake-up reported instead
    task automatic t_crank;
        crank <= 1'b1;
        lowp <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(thr, 1'b1)
        sup <= 1'b1;
        repeat (4) @(posedge clk);
        ex(ph, 8'h00);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        ex(ph, 8'h01);
        crank <= 1'b0;
        sup <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(thr, 1'b0)
        lk(ps, 1'b1, 8'h01);
        ex(ph, 8'h00);
    endtask

    task automatic report_and_stop;
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_sources();
        t_prio();
        t_latch();
        t_crank();
        report_and_stop();
    end
endmodule

`default_nettype wire
